// File: src/etx_pkg.sv
// package for the e1 transmit system-side interface: modes, field layout, timing
package etx_pkg;

  // =====================================================================
  // transmit system-side formats
  typedef enum logic [1:0] {
    ETX_FMT_SR_NRZ = 2'h0,
    ETX_FMT_DR_NRZ = 2'h1,
    ETX_FMT_DR_RZ  = 2'h2
  } etx_fmt_t;

  // =====================================================================
  // second transmit configuration register field positions
  localparam int unsigned ETX_CFGB_INV_BIT = 3;
  localparam int unsigned ETX_CFGB_EDGE_BIT = 4;
  localparam int unsigned ETX_CFGB_SEL_LSB = 5;
  localparam int unsigned ETX_CFGB_SEL_MSB = 7;
  localparam logic [7:0] ETX_CFGB_RESET = 8'h00;

  // indication select codes
  localparam logic [2:0] ETX_IND_PATTERN = 3'h0;
  localparam logic [2:0] ETX_IND_ALARM = 3'h1;
  localparam logic [2:0] ETX_IND_OVERCUR = 3'h2;
  localparam logic [2:0] ETX_IND_TXLOSS = 3'h3;
  localparam logic [2:0] ETX_IND_EXZ = 3'h4;
  localparam logic [2:0] ETX_IND_BPV = 3'h5;
  localparam logic [2:0] ETX_IND_EXZ_BPV = 3'h6;
  localparam logic [2:0] ETX_IND_SIGLOSS = 3'h7;

  // =====================================================================
  // timing: link clock period and loss-of-clock window
  localparam int unsigned ETX_REF_CLK_MHZ = 50;
  localparam int unsigned ETX_LINK_CLK_NS = 488;
  // declare loss after this many link periods without an edge
  localparam int unsigned ETX_LOSS_PERIODS = 4;
  localparam int unsigned ETX_LOSS_CYCLES =
    (ETX_LOSS_PERIODS * ETX_LINK_CLK_NS * ETX_REF_CLK_MHZ) / 1000;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic pos;
    logic neg;
  } etx_rail_t;

  typedef struct packed {
    logic pattern_status;
    logic system_alarm_indication;
    logic driver_overcurrent;
    logic transmit_loss;
    logic system_excess_zeros;
    logic system_bipolar_violation;
    logic system_signal_loss;
  } etx_status_t;

  typedef struct packed {
    logic tip_pos;
    logic tip_neg;
    logic drive_en;
  } etx_line_t;

endpackage

// File: src/etx_tx_sys_if.sv
// e1 transmit system-side interface: sampling, polarity, rail mapping, indication
`timescale 1ns/1ps
module etx_tx_sys_if
  import etx_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = ETX_LOSS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tx_channel_clock,
  input wire logic tx_clock_reset,
  input wire etx_fmt_t tx_format,
  input wire logic [7:0] tx_config_reg_b,
  input wire logic tx_single_rail_data,
  input wire logic tx_negative_rail_in,
  output logic tx_indication_out,
  output logic tx_indication_oe,
  input wire etx_status_t tx_status,
  input wire logic remote_loopback,
  input wire logic internal_pattern_internal_line_clock,
  output etx_line_t line_out,
  output logic line_valid,
  input wire logic line_ready
);

  // =====================================================================
  // configuration decode
  logic tx_data_invert;
  logic tx_clock_edge_select;
  logic [2:0] tx_indication_select;
  logic nrz_mode;
  assign tx_data_invert = tx_config_reg_b[ETX_CFGB_INV_BIT];
  assign tx_clock_edge_select = tx_config_reg_b[ETX_CFGB_EDGE_BIT];
  assign tx_indication_select = tx_config_reg_b[ETX_CFGB_SEL_MSB:ETX_CFGB_SEL_LSB];
  // the clock pin is a clock only in the nrz formats; rz uses it as a rail
  assign nrz_mode = (tx_format != ETX_FMT_DR_RZ);

  function automatic logic ind_pick(input logic [2:0] sel, input etx_status_t st);
    logic v;
    v = 1'b0;
    unique case (sel)
      ETX_IND_PATTERN: v = st.pattern_status;
      ETX_IND_ALARM: v = st.system_alarm_indication;
      ETX_IND_OVERCUR: v = st.driver_overcurrent;
      ETX_IND_TXLOSS: v = st.transmit_loss;
      ETX_IND_EXZ: v = st.system_excess_zeros;
      ETX_IND_BPV: v = st.system_bipolar_violation;
      ETX_IND_EXZ_BPV: v = st.system_excess_zeros | st.system_bipolar_violation;
      ETX_IND_SIGLOSS: v = st.system_signal_loss;
    endcase
    return v;
  endfunction

  // polarity correction shared by the link capture and the rz path; the
  // inversion is applied ahead of the link capture flops, and in the rz path
  // after the second synchroniser flop so that an rz pin meets a bare flop first
  function automatic logic pol_fix(input logic rail, input logic inv);
    return rail ^ inv;
  endfunction

  // =====================================================================
  // link domain: sample on both edges, pick the active one
  // the format and the configuration byte come from the system domain; they
  // are quasi-static, so two link flops per bit keep the link capture out of
  // metastability, at the cost of two link periods before a change takes hold
  etx_fmt_t lfmt_s1_q, lfmt_s1_d, lfmt_s2_q, lfmt_s2_d;
  logic [7:0] lcfg_s1_q, lcfg_s1_d, lcfg_s2_q, lcfg_s2_d;
  logic link_invert;
  logic [2:0] link_select;

  // next values of the link-side configuration copies
  always_comb begin
    lfmt_s1_d = tx_format;
    lfmt_s2_d = lfmt_s1_q;
    lcfg_s1_d = tx_config_reg_b;
    lcfg_s2_d = lcfg_s1_q;
  end

  // configuration synchroniser on the rising link edge
  always_ff @(posedge tx_channel_clock) begin
    if (tx_clock_reset) begin
      lfmt_s1_q <= ETX_FMT_SR_NRZ;
      lfmt_s2_q <= ETX_FMT_SR_NRZ;
      lcfg_s1_q <= ETX_CFGB_RESET;
      lcfg_s2_q <= ETX_CFGB_RESET;
    end else begin
      lfmt_s1_q <= lfmt_s1_d;
      lfmt_s2_q <= lfmt_s2_d;
      lcfg_s1_q <= lcfg_s1_d;
      lcfg_s2_q <= lcfg_s2_d;
    end
  end

  // only the second flop of the synchroniser is read
  assign link_invert = lcfg_s2_q[ETX_CFGB_INV_BIT];
  assign link_select = lcfg_s2_q[ETX_CFGB_SEL_MSB:ETX_CFGB_SEL_LSB];

  etx_rail_t rise_q, rise_d, fall_q, fall_d;
  logic tog_q, tog_d, togf_q, togf_d;
  logic ind_rise_q, ind_rise_d, ind_fall_q, ind_fall_d;
  logic ind_src;
  logic ind_direct;
  // the link flops use the link-side select; rz has no link clock to use
  assign ind_src = ind_pick(link_select, tx_status);
  assign ind_direct = ind_pick(tx_indication_select, tx_status);

  // both edges see the same corrected rails; the edge select picks one later
  always_comb begin
    rise_d.pos = pol_fix(tx_single_rail_data, link_invert);
    rise_d.neg = (lfmt_s2_q == ETX_FMT_SR_NRZ) ? 1'b0 :
      pol_fix(tx_negative_rail_in, link_invert);
    fall_d = rise_d;
    ind_rise_d = ind_src;
    ind_fall_d = ind_src;
    tog_d = ~tog_q;
    togf_d = ~togf_q;
  end

  // rising edge capture and its word strobe toggle
  always_ff @(posedge tx_channel_clock) begin
    if (tx_clock_reset) begin
      rise_q <= '0;
      ind_rise_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      rise_q <= rise_d;
      ind_rise_q <= ind_rise_d;
      tog_q <= tog_d;
    end
  end

  // falling edge capture with a toggle of its own, so that a falling-edge
  // word is never announced by the rising edge half a period before it lands
  always_ff @(negedge tx_channel_clock) begin
    if (tx_clock_reset) begin
      fall_q <= '0;
      ind_fall_q <= 1'b0;
      togf_q <= 1'b0;
    end else begin
      fall_q <= fall_d;
      ind_fall_q <= ind_fall_d;
      togf_q <= togf_d;
    end
  end

  logic ind_link;
  assign ind_link = tx_clock_edge_select ? ind_fall_q : ind_rise_q;
  // the indication leaves from the link flop in nrz and combinationally in rz, driven in non-dual-nrz formats
  assign tx_indication_out = nrz_mode ? ind_link : ind_direct;
  assign tx_indication_oe = (tx_format != ETX_FMT_DR_NRZ);

  // =====================================================================
  // crossing: toggle event plus stable data, two flops before use
  logic [2:0] tog_sync_q, tog_sync_d, togf_sync_q, togf_sync_d;
  etx_rail_t rz_s1_q, rz_s2_q, rz_s1_d, rz_s2_d;

  // next values of the toggle and rz synchronisers
  always_comb begin
    tog_sync_d = {tog_sync_q[1:0], tog_q};
    togf_sync_d = {togf_sync_q[1:0], togf_q};
    // rz rails are unclocked and reach the ref domain through two bare flops
    rz_s1_d.pos = tx_single_rail_data;
    rz_s1_d.neg = tx_channel_clock;
    rz_s2_d = rz_s1_q;
  end

  // synchroniser flops in the system domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tog_sync_q <= 3'h0;
      togf_sync_q <= 3'h0;
      rz_s1_q <= '0;
      rz_s2_q <= '0;
    end else begin
      tog_sync_q <= tog_sync_d;
      togf_sync_q <= togf_sync_d;
      rz_s1_q <= rz_s1_d;
      rz_s2_q <= rz_s2_d;
    end
  end

  // a word is announced by the toggle of the edge that captured it
  logic link_evt_rise, link_evt_fall, link_evt;
  assign link_evt_rise = tog_sync_q[2] ^ tog_sync_q[1];
  assign link_evt_fall = togf_sync_q[2] ^ togf_sync_q[1];
  assign link_evt = tx_clock_edge_select ? link_evt_fall : link_evt_rise;

  // =====================================================================
  // loss of link clock watchdog and rail pick
  logic [$clog2(LOSS_CYCLES+1)-1:0] loss_cnt_q, loss_cnt_d;
  logic clk_lost_q, clk_lost_d;
  etx_rail_t word;
  logic word_valid;
  always_comb begin
    loss_cnt_d = loss_cnt_q;
    clk_lost_d = clk_lost_q;
    if (link_evt) begin
      loss_cnt_d = '0;
      clk_lost_d = 1'b0;
    end else if (loss_cnt_q == LOSS_CYCLES[$bits(loss_cnt_q)-1:0]) begin
      clk_lost_d = 1'b1;
    end else begin
      loss_cnt_d = loss_cnt_q + 1'b1;
    end
    if (nrz_mode) begin
      // the toggle is read two flops after its own capture, so the word is stable
      word = tx_clock_edge_select ? fall_q : rise_q;
      word_valid = link_evt;
    end else begin
      // polarity is fixed only after the second synchroniser flop
      word.pos = pol_fix(rz_s2_q.pos, tx_data_invert);
      word.neg = pol_fix(rz_s2_q.neg, tx_data_invert);
      word_valid = 1'b1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      loss_cnt_q <= '0;
      clk_lost_q <= 1'b1;
    end else begin
      loss_cnt_q <= loss_cnt_d;
      clk_lost_q <= clk_lost_d;
    end
  end

  // =====================================================================
  // two-entry buffer toward the line driver; a word that arrives while it is full is dropped
  etx_line_t mem_q [2];
  etx_line_t mem_d [2];
  logic wr_q, wr_d, rd_q, rd_d;
  logic [1:0] cnt_q, cnt_d;
  logic in_ready, push, pop;
  etx_line_t in_word;
  always_comb begin
    // rail to line mapping after polarity correction
    in_word.tip_pos = word.pos & ~word.neg;
    in_word.tip_neg = word.neg & ~word.pos;
    in_word.drive_en = ~(clk_lost_q & nrz_mode & ~remote_loopback & ~internal_pattern_internal_line_clock);
    in_ready = (cnt_q != 2'h2);
    push = word_valid & in_ready;
    pop = line_valid & line_ready;
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push) begin
      mem_d[wr_q] = in_word;
      wr_d = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_q <= mem_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end
  assign line_valid = (cnt_q != 2'h0);
  assign line_out = mem_q[rd_q];

endmodule

// File: sim/etx_framer_model.sv
// framer model: drives the rails and the link clock of one channel
`timescale 1ns/1ps
module etx_framer_model (
  input wire logic run,
  input wire logic rz_mode,
  input wire logic edge_fall,
  input wire logic pos_set,
  input wire logic neg_set,
  output logic clk_pin,
  output logic pos_out,
  output logic neg_out
);
  // =====================================================================
  // link clock
  logic clk_q = 1'b0;
  logic pos_q = 1'b0;
  // stands low outside frames, 80 ns period in the bench
  always #40 clk_q = run ? ~clk_q : 1'b0;
  // rails move on the inactive edge so they are settled at the sampling edge
  always @(clk_q) if (clk_q == edge_fall) begin
    pos_q <= pos_set;
    neg_out <= neg_set;
  end
  // rz rails carry no clock: the clock pin becomes the negative rail
  assign pos_out = rz_mode ? pos_set : pos_q;
  assign clk_pin = rz_mode ? neg_set : clk_q;
endmodule

// File: sim/etx_tx_sys_if_sva.sv
// port assertions for the e1 transmit system-side interface
`timescale 1ns/1ps
module etx_tx_sys_if_sva
  import etx_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = ETX_LOSS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tx_channel_clock,
  input wire logic tx_clock_reset,
  input wire etx_fmt_t tx_format,
  input wire logic [7:0] tx_config_reg_b,
  input wire logic tx_single_rail_data,
  input wire logic tx_negative_rail_in,
  input wire logic tx_indication_out,
  input wire logic tx_indication_oe,
  input wire etx_status_t tx_status,
  input wire logic remote_loopback,
  input wire logic internal_pattern_internal_line_clock,
  input wire etx_line_t line_out,
  input wire logic line_valid,
  input wire logic line_ready
);
  // =====================================================================
  // sequences; all checks run in the system clock domain
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic inv;
  assign inv = tx_config_reg_b[3];
  // rising link edges in dual rail nrz, sampled on the system clock while the buffer is empty
  sequence s_link_rise;
    tx_format == ETX_FMT_DR_NRZ && $rose(tx_channel_clock) && !line_valid && line_ready;
  endsequence
  // rz rails held still long enough to flush the pipeline
  sequence s_rz_steady;
    (tx_format == ETX_FMT_DR_RZ && line_ready &&
     $stable({tx_single_rail_data, tx_channel_clock, tx_config_reg_b}))[*8];
  endsequence
  AST_OE_NRZ: assert property (tx_format == ETX_FMT_DR_NRZ |-> !tx_indication_oe)
    else $error("indication drives the pin in dual rail nrz");
  AST_OE_IND: assert property (tx_format != ETX_FMT_DR_NRZ |-> tx_indication_oe)
    else $error("indication not driven");
  AST_SPACE: assert property (line_valid |-> !(line_out.tip_pos && line_out.tip_neg))
    else $error("both tip pulses at once");
  AST_HOLD: assert property (line_valid && !line_ready |=> line_valid && $stable(line_out))
    else $error("word lost during stall");
  AST_REL: assert property ($fell(line_valid) |-> $past(line_ready))
    else $error("valid withdrawn without acceptance");
  AST_NRZ_WORD: assert property (s_link_rise |-> ##[1:8] line_valid)
    else $error("no word after link edge");
  AST_IND_LOSS: assert property (tx_format == ETX_FMT_DR_RZ && tx_config_reg_b[7:5] ==
    ETX_IND_SIGLOSS |-> tx_indication_out == tx_status.system_signal_loss)
    else $error("indication does not follow signal loss");
  AST_RZ_MAP: assert property (s_rz_steady |-> line_valid && line_out.tip_pos ==
    ((tx_single_rail_data ^ inv) & ~(tx_channel_clock ^ inv)))
    else $error("rz rails mapped wrongly");
endmodule
bind etx_tx_sys_if etx_tx_sys_if_sva #(.LOSS_CYCLES(LOSS_CYCLES)) etx_tx_sys_if_sva_inst (.*);

// File: sim/testbench.sv
// self-checking bench for the e1 transmit system-side interface
`timescale 1ns/1ps
module testbench;
  import etx_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b1;
  logic rz = 1'b0;
  logic pos = 1'b0;
  logic neg = 1'b0;
  logic line_ready = 1'b1;
  logic [7:0] cfg = 8'h00;
  etx_fmt_t fmt = ETX_FMT_DR_NRZ;
  etx_status_t st = '0;
  logic lclk, dpos, dneg, ind, ind_oe, line_valid, e;
  etx_line_t line_out;
  int fails = 0;
  int checks_done = 0;
  int n;
  always #10 ref_clk = ~ref_clk;
  etx_framer_model etx_framer_model_inst (.run(run), .rz_mode(rz), .edge_fall(cfg[4]),
    .pos_set(pos), .neg_set(neg), .clk_pin(lclk), .pos_out(dpos), .neg_out(dneg));
  // short loss window keeps the run brief
  etx_tx_sys_if #(.LOSS_CYCLES(20)) etx_tx_sys_if_inst (.ref_clk(ref_clk), .reset(reset),
    .tx_channel_clock(lclk), .tx_clock_reset(reset), .tx_format(fmt), .tx_config_reg_b(cfg),
    .tx_single_rail_data(dpos), .tx_negative_rail_in(dneg), .tx_indication_out(ind),
    .tx_indication_oe(ind_oe), .tx_status(st), .remote_loopback(1'b0),
    .internal_pattern_internal_line_clock(1'b0), .line_out(line_out), .line_valid(line_valid),
    .line_ready(line_ready));
  // =====================================================================
  // tasks
  task automatic ticks(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hold a rail pair, wait for a word, compare tip pulses and drive enable
  task automatic rails(input logic p, input logic q, input logic inv);
    logic a, b;
    @(posedge ref_clk);
    pos <= p;
    neg <= q;
    cfg[3] <= inv;
    ticks(60);
    a = p ^ inv;
    b = q ^ inv;
    n = 0;
    while (line_valid !== 1'b1) begin
      ticks(1);
      n++;
      if (n > 40) begin
        fails++;
        finish_test();
      end
    end
    check({5'h0, line_out}, {5'h0, a & ~b, b & ~a, 1'b1});
  endtask
  // =====================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    ticks(20);
    for (int f = 0; f < 3; f++) begin
      @(posedge ref_clk);
      fmt <= etx_fmt_t'(f[1:0]);
      ticks(2);
      check({7'h0, ind_oe}, {7'h0, f != 1});
    end
    // rz: clock pin is the negative rail, indication is combinational
    @(posedge ref_clk);
    run <= 1'b0;
    rz <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int j = 0; j < 7; j++) begin
        @(posedge ref_clk);
        cfg[7:5] <= c[2:0];
        st <= etx_status_t'(7'h1 << j);
        ticks(2);
        e = c < 6 ? j == 6 - c : (c == 6 ? (j == 1 || j == 2) : j == 0);
        check({7'h0, ind}, {7'h0, e});
      end
    end
    for (int k = 0; k < 8; k++) rails(k[0], k[1], k[2]);
    // dual rail nrz on both edges
    @(posedge ref_clk);
    fmt <= ETX_FMT_DR_NRZ;
    rz <= 1'b0;
    run <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      cfg[4] <= k[3];
      rails(k[0], k[1], k[2]);
    end
    // single rail nrz: data on the shared pin, indication from the link flop
    @(posedge ref_clk);
    fmt <= ETX_FMT_SR_NRZ;
    cfg <= 8'he0;
    st <= etx_status_t'(7'h01);
    rails(1'b1, 1'b0, 1'b0);
    check({7'h0, ind}, 8'h01);
    @(posedge ref_clk);
    st <= '0;
    ticks(30);
    check({7'h0, ind}, 8'h00);
    // stall until full, stop the clock, drain: only two words survive
    @(posedge ref_clk);
    line_ready <= 1'b0;
    ticks(60);
    check({7'h0, line_valid}, 8'h01);
    @(posedge ref_clk);
    run <= 1'b0;
    ticks(40);
    @(posedge ref_clk);
    line_ready <= 1'b1;
    #1;
    n = 0;
    // count the words that stand while ready is high, off the clock edge
    repeat (12) begin
      if (line_valid === 1'b1 && line_ready === 1'b1) n++;
      ticks(1);
    end
    check(n[7:0], 8'h02);
    finish_test();
  end
endmodule
